// File: atf_pkg.sv
// Shared constants and types for the task file status and control block
package atf_pkg;

  // Register offsets within the task file
  localparam logic [3:0] ATF_OFF_SECTOR = 4'h3;
  localparam logic [3:0] ATF_OFF_CYL_LO = 4'h4;
  localparam logic [3:0] ATF_OFF_CYL_HI = 4'h5;
  localparam logic [3:0] ATF_OFF_DRIVE_HEAD = 4'h6;
  localparam logic [3:0] ATF_OFF_STATUS = 4'h7;
  localparam logic [3:0] ATF_OFF_ALT_CTRL = 4'hE;
  localparam logic [3:0] ATF_OFF_DRIVE_ADDR = 4'hF;

  // Drive/head field positions
  localparam int ATF_DH_LBA_BIT = 6;
  localparam int ATF_DH_DRV_BIT = 4;

  // Status field positions
  localparam int ATF_ST_BUSY = 7;
  localparam int ATF_ST_RDY = 6;
  localparam int ATF_ST_DWF = 5;
  localparam int ATF_ST_DSC = 4;
  localparam int ATF_ST_DRQ = 3;
  localparam int ATF_ST_CORRECTED_ERROR = 2;
  localparam int ATF_ST_IDX = 1;
  localparam int ATF_ST_ERR = 0;

  // Control field positions
  localparam int ATF_CTL_SRST = 2;
  localparam int ATF_CTL_NIEN = 1;

  // Drive address field positions
  localparam int ATF_DA_WTG = 6;

  // Error register abort bit
  localparam logic [7:0] ATF_ERR_ABORT = 8'h04;

  // Reset values
  localparam logic [7:0] ATF_DH_RESET = 8'hA0;
  localparam logic [7:0] ATF_DH_FIXED = 8'hA0;
  localparam logic [7:0] ATF_CTL_RESET = 8'h00;
  localparam logic [7:0] ATF_CMD_RESET = 8'h00;
  localparam logic [7:0] ATF_DIAG_RESET = 8'h01;
  localparam logic [7:0] ATF_BLANK_BYTE = 8'h00;

  // Depth of the small address register memory
  localparam int ATF_ADDR_DEPTH = 4;
  localparam int ATF_ADDR_AW = 2;

  // Host register access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } atf_host_t;

  // Card core status report
  typedef struct packed {
    logic ready;
    logic write_fault;
    logic data_request;
    logic corrected_error;
    logic cmd_error;
    logic cmd_done;
    logic write_in_progress;
    logic [7:0] error_code;
  } atf_core_t;

  // Host write decode used by the status and control file
  function automatic logic atf_hit(input atf_host_t h, input logic [3:0] off);
    atf_hit = h.wr && (h.addr == off);
  endfunction : atf_hit

endpackage : atf_pkg

// File: atf_addr_mem.sv
// Small register memory for the command block address bytes
`timescale 1ns/1ps
module atf_addr_mem
  import atf_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic we,
  input wire logic [ATF_ADDR_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  output logic [7:0] byte0,
  output logic [7:0] byte1,
  output logic [7:0] byte2
);

  logic [7:0] mem_r [ATF_ADDR_DEPTH];

  // One byte per entry, written only by host address writes
  genvar gi;
  generate
    for (gi = 0; gi < ATF_ADDR_DEPTH; gi++) begin : g_ent
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          mem_r[gi] <= ATF_BLANK_BYTE;
        end else if (we && (waddr == ATF_ADDR_AW'(gi))) begin
          mem_r[gi] <= wdata;
        end
      end
    end
  endgenerate

  // Registered read data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      byte0 <= ATF_BLANK_BYTE;
      byte1 <= ATF_BLANK_BYTE;
      byte2 <= ATF_BLANK_BYTE;
    end else begin
      byte0 <= mem_r[0];
      byte1 <= mem_r[1];
      byte2 <= mem_r[2];
    end
  end

endmodule : atf_addr_mem

// File: atf_status_ctrl.sv
// Task file drive/head, status, control and drive address registers
`timescale 1ns/1ps
module atf_status_ctrl
  import atf_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire atf_host_t host,
  output logic [7:0] rdata,
  input wire atf_core_t core,
  input wire logic core_busy,
  input wire logic own_drive_number,
  output logic lba_mode,
  output logic [27:0] block_address,
  output logic [3:0] head_number,
  output logic drive_selected,
  output logic command_strobe,
  output logic [7:0] command_code,
  output logic soft_reset,
  output logic interrupt_request_n,
  output logic config_int_bit,
  output logic [7:0] error_reg
);

  logic [7:0] drive_head_r;
  logic [7:0] control_r;
  logic [7:0] command_r;
  logic pending_irq_r;
  logic write_fault_r;
  logic data_request_r;
  logic corrected_error_r;
  logic cmd_error_r;
  logic [7:0] error_r;
  logic [7:0] rdata_r;
  logic cmd_strobe_r;
  logic [7:0] sector_b;
  logic [7:0] cyl_lo_b;
  logic [7:0] cyl_hi_b;

  // Host write decode
  wire wr_dh = atf_hit(host, ATF_OFF_DRIVE_HEAD);
  wire wr_cmd = atf_hit(host, ATF_OFF_STATUS);
  wire wr_ctl = atf_hit(host, ATF_OFF_ALT_CTRL);
  wire wr_sec = atf_hit(host, ATF_OFF_SECTOR);
  wire wr_clo = atf_hit(host, ATF_OFF_CYL_LO);
  wire wr_chi = atf_hit(host, ATF_OFF_CYL_HI);
  wire rd_status = host.rd && (host.addr == ATF_OFF_STATUS);
  wire wr_addr = wr_sec || wr_clo || wr_chi;
  wire [ATF_ADDR_AW-1:0] addr_idx = wr_sec ? 2'h0 : (wr_clo ? 2'h1 : 2'h2);

  // Soft reset and interrupt disable from control register
  wire srst = control_r[ATF_CTL_SRST];
  wire nien = control_r[ATF_CTL_NIEN];

  // Busy covers the core and the soft reset period
  wire busy = core_busy || srst;
  wire ready = core.ready && !srst;
  // Commands only taken when not busy
  wire cmd_take = wr_cmd && !busy;

  // Address bytes for the command block
  atf_addr_mem u_addr (
    .clk(clk),
    .resetn(resetn),
    .we(wr_addr),
    .waddr(addr_idx),
    .wdata(host.wdata),
    .byte0(sector_b),
    .byte1(cyl_lo_b),
    .byte2(cyl_hi_b)
  );

  // Drive/head register, writes blocked while busy
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      drive_head_r <= ATF_DH_RESET;
    end else if (wr_dh && !busy) begin
      drive_head_r <= host.wdata | ATF_DH_FIXED;
    end
  end

  // Control register accepted at any time
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      control_r <= ATF_CTL_RESET;
    end else if (wr_ctl) begin
      control_r <= {5'h00, host.wdata[ATF_CTL_SRST], host.wdata[ATF_CTL_NIEN], 1'b0};
    end
  end

  // Command code latch and strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      command_r <= ATF_CMD_RESET;
      cmd_strobe_r <= 1'b0;
    end else begin
      cmd_strobe_r <= cmd_take;
      if (cmd_take) begin
        command_r <= host.wdata;
      end
    end
  end

  // Data request: set by core, cleared by next command or soft reset
  wire drq_nxt = core.data_request ? 1'b1 : ((cmd_take || srst) ? 1'b0 : data_request_r);
  // Error bit: set by core, cleared by next command or soft reset
  wire err_nxt = core.cmd_error ? 1'b1 : ((cmd_take || srst) ? 1'b0 : cmd_error_r);
  // Write fault flag follows same life as error
  wire dwf_nxt = core.write_fault ? 1'b1 : ((cmd_take || srst) ? 1'b0 : write_fault_r);
  // Corrected flag, does not stop a read in progress
  wire corrected_error_nxt = core.corrected_error ? 1'b1 : ((cmd_take || srst) ? 1'b0 : corrected_error_r);

  // Status flags, sets win over clears
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_request_r <= 1'b0;
      cmd_error_r <= 1'b0;
      write_fault_r <= 1'b0;
      corrected_error_r <= 1'b0;
    end else begin
      data_request_r <= drq_nxt;
      cmd_error_r <= err_nxt;
      write_fault_r <= dwf_nxt;
      corrected_error_r <= corrected_error_nxt;
    end
  end

  // Error register: abort on status condition, diagnostic on soft reset
  wire abort_cond = cmd_take && (!ready || write_fault_r);
  wire [7:0] err_reg_nxt = srst ? ATF_DIAG_RESET :
                           (abort_cond ? (error_r | ATF_ERR_ABORT) :
                           (core.cmd_error ? core.error_code :
                           (cmd_take ? ATF_BLANK_BYTE : error_r)));
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      error_r <= ATF_DIAG_RESET;
    end else begin
      error_r <= err_reg_nxt;
    end
  end

  // Pending interrupt: completion sets, primary status read clears
  wire irq_set = core.cmd_done && !nien;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pending_irq_r <= 1'b0;
    end else if (srst) begin
      pending_irq_r <= 1'b0;
    end else if (irq_set) begin
      pending_irq_r <= 1'b1;
    end else if (rd_status) begin
      pending_irq_r <= 1'b0;
    end
  end

  // Status byte, low bits masked while busy
  wire [7:0] status_raw = {1'b0, ready, write_fault_r, ready, data_request_r,
                           corrected_error_r, 1'b0, cmd_error_r};
  wire [7:0] status_byte = busy ? 8'h80 : status_raw;

  // Drive selection against own number
  wire drv_bit = drive_head_r[ATF_DH_DRV_BIT];
  wire selected = (drv_bit == own_drive_number);
  wire drive1_selected_n = !(selected && drv_bit);
  wire nds0 = !(selected && !drv_bit);

  // Drive address byte, bit 7 reads zero
  wire [7:0] drive_addr_byte = {1'b0, !core.write_in_progress, ~drive_head_r[3:0],
                                drive1_selected_n, nds0};

  // Read data select
  wire [7:0] rd_sel = (host.addr == ATF_OFF_DRIVE_HEAD) ? drive_head_r :
                      (host.addr == ATF_OFF_STATUS) ? status_byte :
                      (host.addr == ATF_OFF_ALT_CTRL) ? status_byte :
                      (host.addr == ATF_OFF_DRIVE_ADDR) ? drive_addr_byte :
                      ATF_BLANK_BYTE;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= ATF_BLANK_BYTE;
    end else if (host.rd) begin
      rdata_r <= rd_sel;
    end
  end

  // Addressing, command, reset, interrupt, error and read data outputs
  assign lba_mode = drive_head_r[ATF_DH_LBA_BIT];
  assign block_address = {drive_head_r[3:0], cyl_hi_b, cyl_lo_b, sector_b};
  assign head_number = drive_head_r[3:0];
  assign drive_selected = selected;
  assign command_strobe = cmd_strobe_r;
  assign command_code = command_r;
  assign soft_reset = srst;
  assign interrupt_request_n = !(pending_irq_r && !nien);
  assign config_int_bit = pending_irq_r && !nien;
  assign error_reg = error_r;
  assign rdata = rdata_r;

endmodule : atf_status_ctrl

// File: atf_status_ctrl_checker.sv
// Assertions for the task file status and control block
`timescale 1ns/1ps
module atf_status_ctrl_checker
  import atf_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire atf_host_t host,
  input wire logic [7:0] rdata,
  input wire atf_core_t core,
  input wire logic core_busy,
  input wire logic own_drive_number,
  input wire logic lba_mode,
  input wire logic [27:0] block_address,
  input wire logic [3:0] head_number,
  input wire logic drive_selected,
  input wire logic command_strobe,
  input wire logic [7:0] command_code,
  input wire logic soft_reset,
  input wire logic interrupt_request_n,
  input wire logic config_int_bit,
  input wire logic [7:0] error_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Host access decode
  wire idle = !core_busy && !soft_reset;
  wire st_rd = host.rd && host.addr == 4'h7;
  wire cmd_wr = host.wr && host.addr == 4'h7;
  wire ctl_wr = host.wr && host.addr == 4'hE;
  // Register, status and interrupt relations
  a_dh_mode: assert property (
    host.wr && host.addr == 4'h6 && idle |=> lba_mode == $past(host.wdata[6])
    && head_number == $past(host.wdata[3:0])) else $error("drive head wrong");
  a_stat_clears: assert property (
    st_rd && !core.cmd_done ##1 !core.cmd_done |=> interrupt_request_n)
    else $error("status read kept irq");
  a_alt_keeps: assert property (
    host.rd && host.addr == 4'hE && !host.wr && !soft_reset && !core.cmd_done
    && !interrupt_request_n |=> !interrupt_request_n) else $error("alt read lost irq");
  a_nien_masks: assert property (
    ctl_wr && host.wdata[1] |=> ##[0:1] interrupt_request_n) else $error("irq not masked");
  a_srst_follow: assert property (
    ctl_wr |=> soft_reset == $past(host.wdata[2])) else $error("control write lost");
  a_srst_diag: assert property (
    soft_reset && !core.cmd_error |=> error_reg == ATF_DIAG_RESET) else $error("no diag");
  a_busy_refuse: assert property (
    cmd_wr && !idle |=> !command_strobe) else $error("command taken while busy");
  a_cmd_take: assert property (
    cmd_wr && idle |=> command_strobe && command_code == $past(host.wdata))
    else $error("command not taken");
  a_busy_status: assert property (
    st_rd && core_busy |=> rdata == 8'h80) else $error("busy status wrong");
  // Main scenarios reached
  c_cmd: cover property (cmd_wr && idle);
  c_irq: cover property (!interrupt_request_n);
  c_srst: cover property (soft_reset);
endmodule : atf_status_ctrl_checker

bind atf_status_ctrl atf_status_ctrl_checker atf_status_ctrl_checker_inst (.*);

// File: atf_host_model.sv
// Host side model making task file register cycles
`timescale 1ns/1ps
module atf_host_model
  import atf_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  output atf_host_t host
);
  // Idle bus from time zero
  initial host = '0;
  // One write, released data inverted
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(negedge clk);
    host.addr = a;
    host.wdata = v;
    host.wr = 1'b1;
    @(negedge clk);
    host.wr = 1'b0;
    host.wdata = ~v;
  endtask : wr
  // One byte read; drive address only read on this private bus
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(negedge clk);
    host.addr = a;
    host.rd = 1'b1;
    @(negedge clk);
    host.rd = 1'b0;
    v = rdata;
  endtask : rd
endmodule : atf_host_model

// File: atf_status_ctrl_test.sv
// Testbench for the task file status and control block
`timescale 1ns/1ps
module atf_status_ctrl_test
  import atf_pkg::*;
;
  logic clk;
  logic resetn;
  atf_host_t host;
  atf_core_t core;
  logic core_busy;
  logic own_drive_number;
  logic [7:0] rdata;
  logic lba_mode;
  logic [27:0] block_address;
  logic [3:0] head_number;
  logic drive_selected;
  logic command_strobe;
  logic [7:0] command_code;
  logic soft_reset;
  logic interrupt_request_n;
  logic config_int_bit;
  logic [7:0] error_reg;
  logic [7:0] d;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  // Design and host model
  atf_status_ctrl atf_status_ctrl_inst (.*);
  atf_host_model atf_host_model_inst (.*);
  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (fails == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic put(input logic [3:0] a, input logic [7:0] v);
    atf_host_model_inst.wr(a, v);
  endtask : put
  task automatic get(input logic [3:0] a, output logic [7:0] v);
    atf_host_model_inst.rd(a, v);
  endtask : get
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    get(a, d);
    chk(d, e);
  endtask : rc
  task automatic pulse(input atf_core_t p);
    @(negedge clk);
    core = core | p;
    @(negedge clk);
    core = core & ~p;
  endtask : pulse
  task automatic t_reset();
    rc(4'h6, ATF_DH_RESET);
    rc(4'h7, 8'h00);
  endtask : t_reset
  task automatic t_dh();
    put(4'h3, 8'h11);
    put(4'h4, 8'h22);
    put(4'h5, 8'h33);
    put(4'h6, 8'h5B);
    chk(lba_mode, 1'b1);
    chk(block_address, 28'hB332211);
    chk(head_number, 4'hB);
    chk(drive_selected, 1'b1);
    rc(4'h6, 8'hFB);
    rc(4'hF, {2'b01, ~4'hB, 2'b01});
    put(4'h6, 8'h00);
    chk(lba_mode, 1'b0);
    chk(drive_selected, 1'b0);
    core.write_in_progress = 1'b1;
    get(4'hF, d);
    chk(d[6], 1'b0);
    core.write_in_progress = 1'b0;
  endtask : t_dh
  task automatic t_status();
    core.ready = 1'b1;
    rc(4'h7, 8'h50);
    pulse(15'h1C10);
    rc(4'h7, 8'h5D);
    chk(error_reg, 8'h10);
    put(4'h7, 8'h20);
    chk(command_strobe, 1'b1);
    chk(command_code, 8'h20);
    get(4'h7, d);
    chk(d & 8'h09, 8'h00);
  endtask : t_status
  task automatic t_irq();
    pulse(15'h0200);
    chk(interrupt_request_n, 1'b0);
    get(4'hE, d);
    chk(interrupt_request_n, 1'b0);
    get(4'h7, d);
    chk(config_int_bit, 1'b0);
    put(4'hE, 8'h02);
    pulse(15'h0200);
    chk(interrupt_request_n, 1'b1);
    put(4'hE, 8'h00);
  endtask : t_irq
  task automatic t_busy();
    core_busy = 1'b1;
    rc(4'h7, 8'h80);
    put(4'h6, 8'hF5);
    chk(lba_mode, 1'b0);
    put(4'h7, 8'h30);
    chk(command_strobe, 1'b0);
    put(4'hE, 8'h04);
    chk(soft_reset, 1'b1);
    core_busy = 1'b0;
    rc(4'h7, 8'h80);
    chk(error_reg, ATF_DIAG_RESET);
    put(4'hE, 8'h00);
    chk(soft_reset, 1'b0);
    rc(4'h7, 8'h50);
  endtask : t_busy
  task automatic t_abort();
    pulse(15'h2000);
    rc(4'h7, 8'h70);
    put(4'h7, 8'h20);
    get(4'h7, d);
    chk(error_reg[2], 1'b1);
  endtask : t_abort
  // Main sequence
  initial begin
    resetn = 1'b0;
    core = '0;
    core_busy = 1'b0;
    own_drive_number = 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_dh();
    t_status();
    t_irq();
    t_busy();
    t_abort();
    end_of_test();
  end
endmodule : atf_status_ctrl_test
